// *** pos_check_pkg.sv ***
// Constants, register map and field layout for the positioner address and error check block
// Overview of operation
// - Head load: all ones, one upcount to zero
// - Falling quadrature edge gives one-clock count strobe
// - Strobe counts down if reference high, else up
// - Upcount means toward spindle, downcount away
// - Drive difference on eight lines plus extra line
// - Difference by ones-complement ripple-carry subtraction
// - Carry flop feeds end-around carry and direction
// - Invert subtractor output by carry into LSB stage
// - All-ones counter MSBs force carry, least velocity
// - Three counter MSBs buffered out for temperature compensation
// - Timeout counter advances on slow tick while busy
// - Not busy and no carry: hold counter zero
// - Timeout carry-out asserts seek error, emergency unload
// - Restore holds the timeout counter cleared
// - Limit monitor cleared when purge and load clear
// - Limit monitor set by a falling edge unless held cleared, sticky
// - Travel-limit indicator falling edge arms the monitor
// - Armed monitor: indicator or retract gives limit error
// - Limit error starts emergency unload, even mid-load
// - Demand clear: clear demand, detector; counter all ones
// - Busy set by nonzero difference, cleared after settle
// - Legal demand cylinders run 000 through 405
`default_nettype none
package pos_check_pkg;
  localparam int             CYL_W         = 9;
  localparam int             DIFF_W        = 8;
  localparam int             MSB_W         = 3;
  localparam int             TIMEOUT_W     = 4;
  localparam int             SETTLE_W      = 3;
  localparam int             ADDR_W        = 4;
  localparam logic [8:0]     CYL_ALL_ONES  = 9'h1FF;
  localparam logic [8:0]     CYL_ZERO      = 9'h000;
  localparam logic [8:0]     CYL_MAX_LEGAL = 9'h195;
  localparam logic [8:0]     DIFF_LSB_LVL  = 9'h001;
  localparam logic [2:0]     MSB_ALL_ONES  = 3'h7;
  localparam logic [2:0]     SETTLE_STEPS  = 3'h4;
  localparam logic [3:0]     DEMAND_OFS    = 4'h0;
  localparam logic [3:0]     STATUS_OFS    = 4'h4;
  localparam logic [1:0]     RESP_OKAY     = 2'h0;
  localparam logic [1:0]     RESP_SLVERR   = 2'h2;
  localparam int             ST_FWD_BIT    = 9;
  localparam int             ST_BUSY_BIT   = 10;
  localparam int             ST_PMODE_BIT  = 11;
  localparam int             ST_SEEK_BIT   = 12;
  localparam int             ST_LIMIT_BIT  = 13;
  localparam int             ST_ILL_BIT    = 14;
  localparam int             ST_ARMED_BIT  = 15;
  typedef enum logic [1:0] {SEL_NONE, SEL_DEMAND, SEL_STATUS} reg_sel_t;
endpackage
`default_nettype wire

// *** servo_sync.sv ***
// Synchroniser and falling-edge count strobe for the servo position clocks
`timescale 1ns/1ps
`default_nettype none
module servo_sync
  import pos_check_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic clk_en,
  input  wire logic clear_n,
  input  wire logic quadrature_position_clock,
  input  wire logic ref_position_clock,
  output logic      quad_s,
  output logic      ref_s,
  output logic      count_strobe
);
  logic [1:0] meta_r;
  logic [1:0] sync_r;
  logic       quad_prev_r;
  logic [1:0] raw_in;

  assign raw_in = {ref_position_clock, quadrature_position_clock};

  // Two stages per servo clock; both share the delay so reference stays aligned
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sync
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          meta_r[g] <= 1'b0;
          sync_r[g] <= 1'b0;
        end else if (clk_en) begin
          meta_r[g] <= raw_in[g];
          sync_r[g] <= meta_r[g];
        end
      end
    end
  endgenerate

  assign quad_s = sync_r[0];
  assign ref_s  = sync_r[1];

  // Detector register; held clear while demand clear stands
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      quad_prev_r <= 1'b0;
    end else if (clk_en) begin
      quad_prev_r <= clear_n & quad_s;
    end
  end

  assign count_strobe = clear_n & quad_prev_r & ~quad_s;

  strobe_width_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (clk_en && count_strobe) |=> !count_strobe)
    else $error("count strobe wider than one clock");
endmodule
`default_nettype wire

// *** seek_timeout.sv ***
// Seek time error check counter
`timescale 1ns/1ps
`default_nettype none
module seek_timeout
  import pos_check_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic clk_en,
  input  wire logic busy,
  input  wire logic restore_active,
  input  wire logic slow_count_tick,
  output logic      seek_timeout_error_n
);
  logic [TIMEOUT_W-1:0] count_r;
  logic                 carry_r;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      count_r <= '0;
      carry_r <= 1'b0;
    end else if (clk_en) begin
      if (restore_active) begin
        count_r <= '0;
        carry_r <= 1'b0;
      end else if (!busy && !carry_r) begin
        count_r <= '0;
      end else if (busy && slow_count_tick && !carry_r) begin
        {carry_r, count_r} <= {1'b0, count_r} + {{TIMEOUT_W{1'b0}}, 1'b1};
      end
    end
  end

  // Carry is sticky until a restore, so the unload request cannot drop early
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      seek_timeout_error_n <= 1'b1;
    end else if (clk_en) begin
      seek_timeout_error_n <= ~carry_r;
    end
  end

  hold_zero_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (clk_en && !restore_active && !busy && !carry_r) |=> (count_r == '0))
    else $error("idle timeout counter not held at zero");
  restore_clear_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (clk_en && restore_active) |=> (count_r == '0) && !carry_r)
    else $error("restore did not clear timeout counter");
  count_gate_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (clk_en && !restore_active && busy && !slow_count_tick) |=> $stable(count_r))
    else $error("timeout counter moved without slow tick");
  seek_error_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (clk_en && carry_r && !restore_active) |=> !seek_timeout_error_n)
    else $error("carry-out did not raise seek error");
endmodule
`default_nettype wire

// *** positioner_address_error_check.sv ***
// Current cylinder tracking, difference generator and positioner error checks
//
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module positioner_address_error_check
  import pos_check_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                rstn,
  input  wire logic                clk_en,
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic                quadrature_position_clock,
  input  wire logic                ref_position_clock,
  input  wire logic                demand_clear_n,
  input  wire logic                heads_loading,
  input  wire logic                purge_cycle,
  input  wire logic                restore_active,
  input  wire logic                slow_count_tick,
  input  wire logic                settle_tick,
  input  wire logic                travel_limit_indicator,
  input  wire logic                heads_retract,
  output logic [DIFF_W-1:0]        cyl_diff_n,
  output logic                     cyl_diff_extra_n,
  output logic                     forward_direction,
  output logic [MSB_W-1:0]         temp_comp_msb,
  output logic                     position_mode,
  output logic                     not_busy_time,
  output logic                     seek_timeout_error_n,
  output logic                     travel_limit_error_n,
  output logic                     emergency_unload
);
  logic                 quad_s;
  logic                 ref_s;
  logic                 count_strobe;
  logic [CYL_W-1:0]     cur_cyl_r;
  logic [CYL_W-1:0]     demand_r;
  logic                 carry_r;
  logic                 carry_nxt;
  logic [CYL_W-1:0]     sum;
  logic [CYL_W-1:0]     magnitude;
  logic                 force_carry;
  logic                 busy_r;
  logic [SETTLE_W-1:0]  settle_r;
  logic                 end_busy;
  logic                 pmode_nxt;
  logic                 armed_r;
  logic                 tli_prev_r;
  logic                 illegal_r;
  logic                 aw_held_r;
  logic                 w_held_r;
  logic [ADDR_W-1:0]    awaddr_r;
  logic [31:0]          wdata_r;
  logic [3:0]           wstrb_r;
  logic [CYL_W-1:0]     demand_merge;
  logic                 wr_fire;
  logic                 demand_ok;
  logic                 limit_clear_n;

  function automatic reg_sel_t decode(input logic [ADDR_W-1:0] addr);
    if (addr == DEMAND_OFS) begin
      return SEL_DEMAND;
    end else if (addr == STATUS_OFS) begin
      return SEL_STATUS;
    end
    return SEL_NONE;
  endfunction

  servo_sync u_sync (
    .sys_clk                   (sys_clk),
    .rstn                      (rstn),
    .clk_en                    (clk_en),
    .clear_n                   (demand_clear_n),
    .quadrature_position_clock (quadrature_position_clock),
    .ref_position_clock        (ref_position_clock),
    .quad_s                    (quad_s),
    .ref_s                     (ref_s),
    .count_strobe              (count_strobe)
  );

  // Current cylinder: all ones under demand clear, so the first upcount lands on 000
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cur_cyl_r <= CYL_ALL_ONES;
    end else if (clk_en) begin
      if (!demand_clear_n) begin
        cur_cyl_r <= CYL_ALL_ONES;
      end else if (count_strobe && ref_s) begin
        cur_cyl_r <= cur_cyl_r - 9'h001;
      end else if (count_strobe) begin
        cur_cyl_r <= cur_cyl_r + 9'h001;
      end
    end
  end

  // Ones-complement subtract: cur + ~demand + end-around carry, ripple style
  always_comb begin
    {carry_nxt, sum} = {1'b0, cur_cyl_r} + {1'b0, ~demand_r} + {9'h000, carry_r};
    magnitude = carry_r ? sum : ~sum;
  end

  // Force carry when all three top counter bits are ones, as under head loading
  assign force_carry = (cur_cyl_r[CYL_W-1 -: MSB_W] == MSB_ALL_ONES);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      carry_r           <= 1'b0;
      forward_direction <= 1'b1;
    end else if (clk_en) begin
      carry_r           <= force_carry ? 1'b0 : carry_nxt;
      forward_direction <= force_carry ? 1'b1 : ~carry_nxt;
    end
  end

  // Lines are active low; the forced case asks for the least velocity level
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cyl_diff_n       <= '1;
      cyl_diff_extra_n <= 1'b1;
    end else if (clk_en) begin
      if (force_carry) begin
        {cyl_diff_extra_n, cyl_diff_n} <= ~DIFF_LSB_LVL;
      end else begin
        {cyl_diff_extra_n, cyl_diff_n} <= ~magnitude;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      temp_comp_msb <= '1;
    end else if (clk_en) begin
      temp_comp_msb <= cur_cyl_r[CYL_W-1 -: MSB_W];
    end
  end

  // Position mode: on cylinder and within a quarter track
  assign pmode_nxt = demand_clear_n && (cur_cyl_r == demand_r) && !quad_s;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      position_mode <= 1'b0;
      settle_r      <= '0;
    end else if (clk_en) begin
      position_mode <= pmode_nxt;
      if (!position_mode) begin
        settle_r <= '0;
      end else if (settle_tick && settle_r != SETTLE_STEPS) begin
        settle_r <= settle_r + 3'h1;
      end
    end
  end

  assign end_busy = position_mode && (settle_r == SETTLE_STEPS);

  // Set wins over the end-of-busy clear
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      busy_r        <= 1'b0;
      not_busy_time <= 1'b1;
    end else if (clk_en) begin
      if (demand_clear_n && cur_cyl_r != demand_r) begin
        busy_r <= 1'b1;
      end else if (end_busy) begin
        busy_r <= 1'b0;
      end
      not_busy_time <= ~busy_r;
    end
  end

  seek_timeout u_timeout (
    .sys_clk              (sys_clk),
    .rstn                 (rstn),
    .clk_en               (clk_en),
    .busy                 (busy_r),
    .restore_active       (restore_active),
    .slow_count_tick      (slow_count_tick),
    .seek_timeout_error_n (seek_timeout_error_n)
  );

  assign limit_clear_n = purge_cycle | heads_loading;

  // J tied high: an indicator fall sets unless the clear term holds it; only the clear term releases
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      armed_r    <= 1'b0;
      tli_prev_r <= 1'b0;
    end else if (clk_en) begin
      tli_prev_r <= travel_limit_indicator;
      if (!limit_clear_n) begin
        armed_r <= 1'b0;
      end else if (tli_prev_r && !travel_limit_indicator) begin
        armed_r <= 1'b1;
      end
    end
  end

  // A second indicator pulse during load trips here before load completes
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      travel_limit_error_n <= 1'b1;
      emergency_unload     <= 1'b0;
    end else if (clk_en) begin
      travel_limit_error_n <= ~(armed_r && (travel_limit_indicator || heads_retract));
      emergency_unload     <= ~travel_limit_error_n || ~seek_timeout_error_n;
    end
  end

  // Register write path: address and data taken in either order
  assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;

  always_comb begin
    demand_merge[8]   = wstrb_r[1] ? wdata_r[8] : demand_r[8];
    demand_merge[7:0] = wstrb_r[0] ? wdata_r[7:0] : demand_r[7:0];
  end

  // Busy seeks refuse a new demand, as an out-of-range one is refused
  assign demand_ok = (demand_merge <= CYL_MAX_LEGAL) && !busy_r && demand_clear_n;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      awaddr_r      <= '0;
      wdata_r       <= '0;
      wstrb_r       <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready  <= !w_held_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      if (wr_fire) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (decode(awaddr_r) == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Demand register and illegal flag; a refused write sets the flag
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      demand_r  <= CYL_ZERO;
      illegal_r <= 1'b0;
    end else if (clk_en) begin
      if (!demand_clear_n) begin
        demand_r <= CYL_ZERO;
      end else if (wr_fire && decode(awaddr_r) == SEL_DEMAND && demand_ok) begin
        demand_r <= demand_merge;
      end
      if (wr_fire && decode(awaddr_r) == SEL_DEMAND) begin
        illegal_r <= !demand_ok;
      end
    end
  end

  // Read path
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (clk_en) begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        s_axi_rdata  <= '0;
        unique case (decode(s_axi_araddr))
          SEL_DEMAND: begin
            s_axi_rdata[CYL_W-1:0] <= demand_r;
          end
          SEL_STATUS: begin
            s_axi_rdata[CYL_W-1:0]    <= cur_cyl_r;
            s_axi_rdata[ST_FWD_BIT]   <= forward_direction;
            s_axi_rdata[ST_BUSY_BIT]  <= busy_r;
            s_axi_rdata[ST_PMODE_BIT] <= position_mode;
            s_axi_rdata[ST_SEEK_BIT]  <= ~seek_timeout_error_n;
            s_axi_rdata[ST_LIMIT_BIT] <= ~travel_limit_error_n;
            s_axi_rdata[ST_ILL_BIT]   <= illegal_r;
            s_axi_rdata[ST_ARMED_BIT] <= armed_r;
          end
          SEL_NONE: begin
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  count_down_a: assert property (
    (clk_en && demand_clear_n && count_strobe && ref_s) |=> cur_cyl_r == $past(cur_cyl_r) - 9'h001)
    else $error("downcount missing with reference high");
  count_up_a: assert property (
    (clk_en && demand_clear_n && count_strobe && !ref_s)
    |=> cur_cyl_r == $past(cur_cyl_r) + 9'h001)
    else $error("upcount missing with reference low");
  clear_load_a: assert property (
    (clk_en && !demand_clear_n) |=> (cur_cyl_r == CYL_ALL_ONES) && (demand_r == CYL_ZERO))
    else $error("demand clear did not initialise counter and demand");
  diff_mag_a: assert property (
    (clk_en && !force_carry && $stable(cur_cyl_r) && $stable(demand_r) && $past(clk_en))
    |=> {cyl_diff_extra_n, cyl_diff_n} ==
        ~(($past(cur_cyl_r) >= $past(demand_r)) ? $past(cur_cyl_r) - $past(demand_r)
                                                 : $past(demand_r) - $past(cur_cyl_r)))
    else $error("difference lines do not show magnitude");
  direction_a: assert property (
    (clk_en && !force_carry && cur_cyl_r < demand_r) |=> forward_direction)
    else $error("forward direction not set for upward seek");
  forced_lsb_a: assert property (
    (clk_en && force_carry) |=> {cyl_diff_extra_n, cyl_diff_n} == ~DIFF_LSB_LVL && !carry_r)
    else $error("loading did not force least velocity");
  msb_out_a: assert property (
    clk_en |=> temp_comp_msb == $past(cur_cyl_r[CYL_W-1 -: MSB_W]))
    else $error("temperature bits do not follow counter");
  busy_set_a: assert property (
    (clk_en && demand_clear_n && cur_cyl_r != demand_r) |=> busy_r ##1 !not_busy_time)
    else $error("nonzero difference did not set busy");
  arm_clear_a: assert property (
    (clk_en && !purge_cycle && !heads_loading) |=> !armed_r)
    else $error("limit monitor not held clear");
  limit_error_a: assert property (
    (clk_en && armed_r && (travel_limit_indicator || heads_retract)) |=> !travel_limit_error_n)
    else $error("armed monitor missed limit fault");
endmodule
`default_nettype wire

// *** servo_model.sv ***
// Servo board transducer model: one quadrature cycle per cylinder step
`timescale 1ns/1ps
`default_nettype none
module servo_model (
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic step_req,
  input  wire logic step_up,
  output logic      quadrature_position_clock,
  output logic      ref_position_clock,
  output logic      step_busy
);
  logic [3:0] phase_r;
  // Quadrature high 8 cycles then low, so edges sit far wider than the synchroniser needs
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) phase_r <= 4'h0;
    else if (phase_r != 4'h0) phase_r <= phase_r - 4'h1;
    else if (step_req) phase_r <= 4'hF;
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) ref_position_clock <= 1'b0;
    else if (step_req && phase_r == 4'h0) ref_position_clock <= ~step_up;
  end
  assign quadrature_position_clock = phase_r[3];
  assign step_busy = phase_r != 4'h0;
endmodule
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the positioner address and error check block
`timescale 1ns/1ps
`default_nettype none
module testbench
  import pos_check_pkg::*;
;
  logic sys_clk, rstn = 1'b0, step_req = 1'b0, step_up = 1'b0, step_busy;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, demand_clear_n = 1'b0;
  logic heads_loading = 1'b0, purge_cycle = 1'b0, restore_active = 1'b0;
  logic slow_count_tick = 1'b0, settle_tick = 1'b0;
  logic travel_limit_indicator = 1'b0, heads_retract = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic quadrature_position_clock, ref_position_clock, cyl_diff_extra_n, forward_direction;
  logic position_mode, not_busy_time, seek_timeout_error_n, travel_limit_error_n;
  logic emergency_unload;
  logic [DIFF_W-1:0] cyl_diff_n;
  logic [MSB_W-1:0] temp_comp_msb;
  logic [8:0] cur = 9'h1FF, dem = 9'h000;
  logic [9:0] dvec;
  assign dvec = {forward_direction, cyl_diff_extra_n, cyl_diff_n};
  int fail_count = 0, n_tests = 0, cyc = 0;

  positioner_address_error_check positioner_address_error_check_i (.sys_clk, .rstn,
    .clk_en(1'b1), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .quadrature_position_clock,
    .ref_position_clock, .demand_clear_n, .heads_loading, .purge_cycle, .restore_active,
    .slow_count_tick, .settle_tick, .travel_limit_indicator, .heads_retract, .cyl_diff_n,
    .cyl_diff_extra_n, .forward_direction, .temp_comp_msb, .position_mode, .not_busy_time,
    .seek_timeout_error_n, .travel_limit_error_n, .emergency_unload);
  servo_model servo_model_i (.sys_clk, .rstn, .step_req, .step_up,
    .quadrature_position_clock, .ref_position_clock, .step_busy);

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Generous: the longest seek is about 9000 cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      fail_count++;
      final_report();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
  endtask

  task automatic axr(input logic [3:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask

  // Expected direction flag and active-low magnitude lines
  function automatic logic [9:0] exp_out(input logic [8:0] c, input logic [8:0] d);
    logic [8:0] m;
    m = (c > d) ? c - d : d - c;
    return {d > c, ~m};
  endfunction

  task automatic cdiff;
    if (cur != dem) chk("diff", dvec, exp_out(cur, dem));
  endtask

  task automatic pulse(input logic settle, input int n);
    repeat (n) begin
      @(posedge sys_clk);
      if (settle) settle_tick <= 1'b1;
      else slow_count_tick <= 1'b1;
      @(posedge sys_clk);
      settle_tick <= 1'b0;
      slow_count_tick <= 1'b0;
    end
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic step(input logic up);
    @(posedge sys_clk);
    step_up <= up;
    step_req <= 1'b1;
    @(posedge sys_clk);
    step_req <= 1'b0;
    do @(posedge sys_clk); while (step_busy);
    repeat (5) @(posedge sys_clk);
    cur = up ? cur + 9'h001 : cur - 9'h001;
  endtask

  task automatic seek(input logic [8:0] d);
    axw(DEMAND_OFS, {23'h0, d});
    dem = d;
    repeat (5) @(posedge sys_clk);
    cdiff();
    chk("busy", not_busy_time, d == cur);
    while (cur != d) begin
      step(d > cur);
      cdiff();
    end
    chk("pmode", position_mode, 1'b1);
    axr(STATUS_OFS);
    chk("cur", rd[8:0], cur);
    pulse(1'b1, 5);
    chk("idle", not_busy_time, 1'b1);
    chk("msb", temp_comp_msb, cur[8:6]);
  endtask

  task automatic lim(input logic ind, input logic ret, input logic [1:0] exp);
    @(posedge sys_clk);
    travel_limit_indicator <= ind;
    heads_retract <= ret;
    repeat (4) @(posedge sys_clk);
    chk("limit", {travel_limit_error_n, emergency_unload}, exp);
  endtask

  initial begin
    void'($urandom(32'h6EE2));
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    axr(DEMAND_OFS);
    chk("dem_rst", rd, 32'h0);
    axr(4'h8);
    chk("unmapped", rsp, RESP_SLVERR);
    axw(4'h8, 32'h0);
    chk("wr_unmapped", rsp, RESP_SLVERR);
    axr(STATUS_OFS);
    chk("clear_cur", rd[8:0], 9'h1FF);
    chk("lsb_lvl", {forward_direction, cyl_diff_extra_n, cyl_diff_n}, 10'h3FE);
    chk("msb7", temp_comp_msb, 3'h7);
    demand_clear_n <= 1'b1;
    step(1'b1);
    axr(STATUS_OFS);
    chk("load", rd[8:0], 9'h000);
    pulse(1'b1, 5);
    axw(DEMAND_OFS, 32'h196);
    chk("wr_ok", rsp, RESP_OKAY);
    axr(STATUS_OFS);
    chk("illegal", rd[14], 1'b1);
    axr(DEMAND_OFS);
    chk("dem_keep", rd, 32'h0);
    seek(9'h195);
    for (int i = 0; i < 2; i++) seek(9'($urandom_range(405, 0)));
    seek(9'h000);
    dem = cur + 9'h001;
    axw(DEMAND_OFS, {23'h0, dem});
    axw(DEMAND_OFS, 32'h5);
    axr(DEMAND_OFS);
    chk("dem_busy", rd[8:0], dem);
    restore_active <= 1'b1;
    pulse(1'b0, 20);
    chk("restore", seek_timeout_error_n, 1'b1);
    restore_active <= 1'b0;
    pulse(1'b0, 15);
    chk("early", seek_timeout_error_n, 1'b1);
    pulse(1'b0, 1);
    chk("timeout", {seek_timeout_error_n, emergency_unload}, 2'b01);
    restore_active <= 1'b1;
    step(1'b1);
    pulse(1'b1, 5);
    restore_active <= 1'b0;
    pulse(1'b0, 20);
    chk("no_busy", {seek_timeout_error_n, emergency_unload}, 2'b10);
    lim(1'b1, 1'b0, 2'b10);
    lim(1'b0, 1'b1, 2'b10);
    heads_loading <= 1'b1;
    lim(1'b1, 1'b0, 2'b10);
    lim(1'b0, 1'b0, 2'b10);
    axr(STATUS_OFS);
    chk("armed", rd[15], 1'b1);
    lim(1'b1, 1'b0, 2'b01);
    lim(1'b0, 1'b1, 2'b01);
    lim(1'b0, 1'b0, 2'b10);
    heads_loading <= 1'b0;
    purge_cycle <= 1'b1;
    lim(1'b0, 1'b1, 2'b01);
    purge_cycle <= 1'b0;
    lim(1'b0, 1'b1, 2'b10);
    final_report();
  end
endmodule
`default_nettype wire
